//--- inc/svmon_pkg.sv
/*
  svmon_pkg: register map, field layout, reset values and timing constants
  of the supply monitor. Assumes a 25 MHz system clock and a 32-bit APB.
*/
package svmon_pkg;

  // register byte offsets
  localparam logic [11:0] SVMON_CTRL_OFF   = 12'h000;
  localparam logic [11:0] SVMON_STAT_OFF   = 12'h004;
  localparam logic [11:0] SVMON_IEN_OFF    = 12'h008;
  localparam logic [11:0] SVMON_ICLR_OFF   = 12'h00c;
  localparam logic [11:0] SVMON_SYS_OFF    = 12'h010;

  // control field positions
  localparam int SVMON_LVL_LSB  = 0;
  localparam int SVMON_LVL_W    = 4;
  localparam int SVMON_EN_BIT   = 4;
  localparam int SVMON_RDY_BIT  = 5;

  // status / enable / clear layout
  localparam int SVMON_FLAG_BIT = 0;
  // system register layout
  localparam int SVMON_GIE_BIT  = 0;
  localparam int SVMON_SLP_BIT  = 1;

  // control reset: power off, level field 0101
  localparam logic [7:0] SVMON_CTRL_RST = 8'h05;

  localparam logic [3:0] SVMON_LVL_EXT  = 4'hf;
  localparam logic [3:0] SVMON_LVL_RSVD = 4'h0;

  // reference settle time, fixed in time, not in clocks
  localparam int SVMON_CLK_MHZ    = 25;
  localparam int SVMON_SETTLE_US  = 20;
  localparam int SVMON_SETTLE_CYC = SVMON_SETTLE_US * SVMON_CLK_MHZ;

  typedef struct packed {
    logic       ref_ok;
    logic       enable;
    logic [3:0] level;
  } svmon_ctrl_t;

  typedef enum logic [1:0] {
    SVMON_OFF    = 2'b00,
    SVMON_SETTLE = 2'b01,
    SVMON_RUN    = 2'b11
  } svmon_state_t;

endpackage : svmon_pkg

//--- src/svmon_top.sv
/*
  svmon_top: supply-voltage monitor control logic behind an APB slave.
  Assumes the analog comparator, ladder and reference live outside and
  reach this block as asynchronous levels; they are synchronised here.
*/
`timescale 1ns/100ps

// Summary of operation
// - low supply below selected tap against reference sets the flag
// - comparator trip at reference equality raises the flag
// - software picks one of 16 level codes in control bits 3..0, 15 of which can trip
// - level code 1111 routes the external detect pin to the comparator
// - codes 0001..1110 internal taps; code 0000 reserved, never trips
// - bit 4 powers up and enables the detector
// - bit 5 read-only, high when reference stable and detector can trip
// - control bits 7 and 6 read as zero
// - no flag before the reference settles after enabling
// - flag with its enable set raises the interrupt to the processor
// - detector runs in sleep; trip wakes; vectoring needs global enable
// - reset returns control register to reset state, detector off
module svmon_top
  import svmon_pkg::*;
#(
  parameter int SETTLE_CYC = SVMON_SETTLE_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // analog front end
  input  wire logic        tap_below_ref_i,
  input  wire logic        ext_below_ref_i,
  input  wire logic        ref_stable_i,
  output logic             detect_power_o,
  output logic [3:0]       tap_select_o,
  output logic             ext_select_o,
  // processor side
  output logic             irq_o,
  output logic             vector_o,
  output logic             wake_o
);

  // the settle counter is 16 bits wide and needs at least one cycle
  if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_settle_chk
    $error("SETTLE_CYC out of range");
  end

  // two-stage synchronisers for analog levels
  logic [2:0] sync1_reg, sync2_reg;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= {ref_stable_i, ext_below_ref_i, tap_below_ref_i};
      sync2_reg <= sync1_reg;
    end
  end
  logic tap_low, ext_low, ref_ok_in;
  assign tap_low   = sync2_reg[0];
  assign ext_low   = sync2_reg[1];
  assign ref_ok_in = sync2_reg[2];

  // registers
  logic [3:0]   level_reg, level_next;
  logic         en_reg, en_next;
  logic         flag_reg, flag_next;
  logic         ien_reg, ien_next;
  logic         gie_reg, gie_next;
  logic         sleep_reg, sleep_next;
  svmon_state_t st_reg, st_next;
  logic [15:0]  cnt_reg, cnt_next;
  logic [31:0]  rdata_reg, rdata_next;

  logic wr, rd, hit, trip, ready_flag;
  assign wr = psel_i & penable_i & pwrite_i;
  assign rd = psel_i & ~penable_i & ~pwrite_i;
  assign hit = (paddr_i == SVMON_CTRL_OFF) | (paddr_i == SVMON_STAT_OFF) |
               (paddr_i == SVMON_IEN_OFF)  | (paddr_i == SVMON_ICLR_OFF) |
               (paddr_i == SVMON_SYS_OFF);

  // gated by enable so a disable stops trips at once, not one cycle later
  assign ready_flag = (st_reg == SVMON_RUN) & en_reg;

  always_comb begin
    trip = 1'b0;
    if (ready_flag) begin
      if (level_reg == SVMON_LVL_EXT)
        trip = ext_low;
      else if (level_reg != SVMON_LVL_RSVD)
        trip = tap_low;
    end
  end

  // settle sequencer
  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      SVMON_OFF: begin
        cnt_next = 16'h0;
        if (en_reg)
          st_next = SVMON_SETTLE;
      end
      SVMON_SETTLE: begin
        if (!en_reg) begin
          st_next = SVMON_OFF;
        end else if (cnt_reg >= 16'(SETTLE_CYC - 1) && ref_ok_in) begin
          st_next = SVMON_RUN;
        end else if (cnt_reg < 16'(SETTLE_CYC - 1)) begin
          cnt_next = cnt_reg + 16'h1;
        end
      end
      SVMON_RUN: begin
        if (!en_reg || !ref_ok_in)
          st_next = SVMON_OFF;
      end
      default: st_next = SVMON_OFF;
    endcase
  end

  // register writes
  always_comb begin
    level_next = level_reg;
    en_next    = en_reg;
    ien_next   = ien_reg;
    gie_next   = gie_reg;
    sleep_next = sleep_reg;
    flag_next  = flag_reg;
    if (wr) begin
      case (paddr_i)
        SVMON_CTRL_OFF: begin
          level_next = pwdata_i[SVMON_LVL_LSB +: SVMON_LVL_W];
          en_next    = pwdata_i[SVMON_EN_BIT];
        end
        SVMON_IEN_OFF:  ien_next = pwdata_i[SVMON_FLAG_BIT];
        SVMON_ICLR_OFF: begin
          if (pwdata_i[SVMON_FLAG_BIT])
            flag_next = 1'b0;
        end
        SVMON_SYS_OFF: begin
          gie_next   = pwdata_i[SVMON_GIE_BIT];
          sleep_next = pwdata_i[SVMON_SLP_BIT];
        end
        default: ;
      endcase
    end
    // set wins over clear; sticky until cleared
    if (trip)
      flag_next = 1'b1;
    // a wake ends sleep
    if (sleep_reg && flag_reg)
      sleep_next = 1'b0;
  end

  // read mux, captured in setup phase
  always_comb begin
    rdata_next = rdata_reg;
    if (rd) begin
      case (paddr_i)
        SVMON_CTRL_OFF: rdata_next = {26'h0, ready_flag, en_reg,
                                      level_reg};
        SVMON_STAT_OFF: rdata_next = {31'h0, flag_reg};
        SVMON_IEN_OFF:  rdata_next = {31'h0, ien_reg};
        SVMON_SYS_OFF:  rdata_next = {30'h0, sleep_reg, gie_reg};
        default:        rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      level_reg <= SVMON_CTRL_RST[3:0];
      en_reg    <= SVMON_CTRL_RST[4];
      flag_reg  <= 1'b0;
      ien_reg   <= 1'b0;
      gie_reg   <= 1'b0;
      sleep_reg <= 1'b0;
      st_reg    <= SVMON_OFF;
      cnt_reg   <= 16'h0;
      rdata_reg <= 32'h0;
    end else begin
      level_reg <= level_next;
      en_reg    <= en_next;
      flag_reg  <= flag_next;
      ien_reg   <= ien_next;
      gie_reg   <= gie_next;
      sleep_reg <= sleep_next;
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      rdata_reg <= rdata_next;
    end
  end

  // outputs
  assign prdata_o       = rdata_reg;
  assign pready_o       = 1'b1;
  assign pslverr_o      = psel_i & penable_i & ~hit;
  assign detect_power_o = en_reg;
  assign tap_select_o   = level_reg;
  assign ext_select_o   = en_reg & (level_reg == SVMON_LVL_EXT);
  assign irq_o          = flag_reg & ien_reg;
  assign vector_o       = irq_o & gie_reg & ~sleep_reg;
  assign wake_o         = sleep_reg & flag_reg;

  // assertions
  AST_NO_FLAG_OFF: assert property (@(posedge clk_i) disable iff (reset_i)
    (!en_reg && !flag_reg) |=> !flag_reg)
    else $error("flag set while detector off");
  AST_SETTLE: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(ready_flag) |-> cnt_reg >= 16'(SETTLE_CYC - 1))
    else $error("ready before settle time");
  AST_STICKY: assert property (@(posedge clk_i) disable iff (reset_i)
    (flag_reg && !(wr && paddr_i == SVMON_ICLR_OFF)) |=> flag_reg)
    else $error("flag lost without clear");
  AST_TRIP: assert property (@(posedge clk_i) disable iff (reset_i)
    (ready_flag && level_reg != SVMON_LVL_EXT &&
     level_reg != SVMON_LVL_RSVD && tap_low) |=> flag_reg)
    else $error("tap trip did not set flag");
  AST_EXT: assert property (@(posedge clk_i) disable iff (reset_i)
    (ready_flag && level_reg == SVMON_LVL_EXT && ext_low) |=> flag_reg)
    else $error("external trip did not set flag");
  AST_RSVD: assert property (@(posedge clk_i) disable iff (reset_i)
    (level_reg == SVMON_LVL_RSVD) |-> !trip)
    else $error("reserved level tripped");
  AST_IRQ: assert property (@(posedge clk_i) disable iff (reset_i)
    irq_o == (flag_reg && ien_reg))
    else $error("irq mismatch");
  AST_RDZERO: assert property (@(posedge clk_i) disable iff (reset_i)
    (rd && paddr_i == SVMON_CTRL_OFF) |=> prdata_o[7:6] == 2'b00)
    else $error("unimplemented bits nonzero");
  AST_OFFDROP: assert property (@(posedge clk_i) disable iff (reset_i)
    !en_reg |=> ##1 !ready_flag)
    else $error("ready while disabled");
  AST_RESET: assert property (@(posedge clk_i)
    reset_i |=> !en_reg && st_reg == SVMON_OFF)
    else $error("reset did not turn detector off");
  AST_WAKE: assert property (@(posedge clk_i) disable iff (reset_i)
    (sleep_reg && flag_reg) |=> !sleep_reg)
    else $error("no wake on flag");
  AST_NO_TRIP_SETTLE: assert property (@(posedge clk_i) disable iff (reset_i)
    (st_reg != SVMON_RUN) |-> !trip)
    else $error("trip before reference settled");
  AST_REF_LOSS: assert property (@(posedge clk_i) disable iff (reset_i)
    !ref_ok_in |=> !ready_flag)
    else $error("ready kept after reference loss");
  AST_OFF_NO_TRIP: assert property (@(posedge clk_i) disable iff (reset_i)
    !en_reg |-> !trip)
    else $error("trip while detector disabled");
  AST_LVL_WR: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr && paddr_i == SVMON_CTRL_OFF) |=>
    tap_select_o == $past(pwdata_i[SVMON_LVL_LSB +: SVMON_LVL_W]))
    else $error("level select not taken from write");
  AST_PWR_WR: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr && paddr_i == SVMON_CTRL_OFF) |=>
    detect_power_o == $past(pwdata_i[SVMON_EN_BIT]))
    else $error("power enable not taken from write");
  AST_EXT_SEL: assert property (@(posedge clk_i) disable iff (reset_i)
    ext_select_o |-> (detect_power_o && tap_select_o == SVMON_LVL_EXT))
    else $error("external input routed in wrong mode");
  AST_NO_VEC: assert property (@(posedge clk_i) disable iff (reset_i)
    !gie_reg |-> !vector_o)
    else $error("vector without global enable");
  AST_CLEAR: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr && paddr_i == SVMON_ICLR_OFF && pwdata_i[SVMON_FLAG_BIT] && !trip)
    |=> !flag_reg)
    else $error("flag not cleared by write one");

  COV_RUN:  cover property (@(posedge clk_i) disable iff (reset_i)
    $rose(ready_flag));
  COV_TRIP: cover property (@(posedge clk_i) disable iff (reset_i)
    $rose(flag_reg));
  COV_EXT:  cover property (@(posedge clk_i) disable iff (reset_i)
    trip && level_reg == SVMON_LVL_EXT);
  COV_WAKE: cover property (@(posedge clk_i) disable iff (reset_i)
    wake_o);
  COV_REF_LOSS: cover property (@(posedge clk_i) disable iff (reset_i)
    $fell(ready_flag) && en_reg);

endmodule : svmon_top

//--- verification/svmon_bench.sv
/*
  svmon_bench: self-checking bench for svmon_top, driven over APB.
  Assumes svmon_pkg and a short settle count; the analog side is driven here.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin #1; checks_done++; if ((g) !== (e)) begin \
  err_total++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module svmon_bench;
  import svmon_pkg::*;
  logic        clk_i           = 1'b0;
  logic        reset_i         = 1'b1;
  logic        psel_i          = 1'b0;
  logic        penable_i       = 1'b0;
  logic        pwrite_i        = 1'b0;
  logic [11:0] paddr_i         = 12'h000;
  logic [31:0] pwdata_i        = 32'h0;
  logic        tap_below_ref_i = 1'b0;
  logic        ext_below_ref_i = 1'b0;
  logic        ref_stable_i    = 1'b1;
  logic [31:0] prdata_o, rd;
  logic        pready_o, pslverr_o, detect_power_o, ext_select_o, er;
  logic        irq_o, vector_o, wake_o;
  logic [3:0]  tap_select_o;
  int          err_total   = 0;
  int          checks_done = 0;

  svmon_top #(.SETTLE_CYC(4)) dut_u (.clk_i(clk_i), .reset_i(reset_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .tap_below_ref_i(tap_below_ref_i), .ext_below_ref_i(ext_below_ref_i),
    .ref_stable_i(ref_stable_i), .detect_power_o(detect_power_o),
    .tap_select_o(tap_select_o), .ext_select_o(ext_select_o),
    .irq_o(irq_o), .vector_o(vector_o), .wake_o(wake_o));

  always #20 clk_i = ~clk_i;

  task automatic give_verdict;
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // one transfer; read data and error taken at the completing edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rd_chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // bounded poll; the watchdog covers nothing here
  task automatic wait_rdy;
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, SVMON_CTRL_OFF, 32'h0);
      if (rd[5] === 1'b1) break;
    end
  endtask : wait_rdy

  initial begin
    #400000;
    err_total++;
    give_verdict();
  end

  initial begin
    tick(12);
    reset_i <= 1'b0;
    rd_chk(SVMON_CTRL_OFF, 32'h05);
    `CHK({tap_select_o, detect_power_o, irq_o}, 6'h14)
    apb(1'b0, 12'h020, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    tick(1);
    ext_below_ref_i <= 1'b1;
    apb(1'b1, SVMON_CTRL_OFF, 32'hff);
    `CHK({detect_power_o, ext_select_o}, 2'b11)
    rd_chk(SVMON_STAT_OFF, 32'h0);
    wait_rdy();
    `CHK(rd, 32'h3f)
    tick(6);
    rd_chk(SVMON_STAT_OFF, 32'h1);
    tick(1);
    ext_below_ref_i <= 1'b0;
    tick(6);
    rd_chk(SVMON_STAT_OFF, 32'h1);
    apb(1'b1, SVMON_ICLR_OFF, 32'h1);
    rd_chk(SVMON_STAT_OFF, 32'h0);
    tick(1);
    tap_below_ref_i <= 1'b1;
    apb(1'b1, SVMON_CTRL_OFF, 32'h13);
    tick(6);
    rd_chk(SVMON_STAT_OFF, 32'h1);
    `CHK({tap_select_o, ext_select_o}, 5'h06)
    apb(1'b1, SVMON_IEN_OFF, 32'h1);
    `CHK({irq_o, vector_o}, 2'b10)
    apb(1'b1, SVMON_SYS_OFF, 32'h1);
    `CHK(vector_o, 1'b1)
    apb(1'b1, SVMON_IEN_OFF, 32'h0);
    `CHK({irq_o, vector_o}, 2'b00)
    tick(1);
    tap_below_ref_i <= 1'b0;
    tick(4);
    apb(1'b1, SVMON_ICLR_OFF, 32'h1);
    apb(1'b1, SVMON_IEN_OFF, 32'h1);
    apb(1'b1, SVMON_SYS_OFF, 32'h2);
    rd_chk(SVMON_SYS_OFF, 32'h2);
    `CHK(wake_o, 1'b0)
    tick(1);
    tap_below_ref_i <= 1'b1;
    tick(3);
    `CHK(wake_o, 1'b1)
    tick(4);
    rd_chk(SVMON_SYS_OFF, 32'h0);
    `CHK({irq_o, vector_o}, 2'b10)
    apb(1'b1, SVMON_CTRL_OFF, 32'h10);
    apb(1'b1, SVMON_ICLR_OFF, 32'h1);
    tick(6);
    rd_chk(SVMON_STAT_OFF, 32'h0);
    tick(1);
    ref_stable_i <= 1'b0;
    tick(4);
    rd_chk(SVMON_CTRL_OFF, 32'h10);
    tick(1);
    ref_stable_i <= 1'b1;
    wait_rdy();
    `CHK(rd, 32'h30)
    apb(1'b1, SVMON_CTRL_OFF, 32'h03);
    `CHK(detect_power_o, 1'b0)
    rd_chk(SVMON_CTRL_OFF, 32'h03);
    tick(1);
    reset_i <= 1'b1;
    tick(2);
    reset_i <= 1'b0;
    rd_chk(SVMON_CTRL_OFF, 32'h05);
    give_verdict();
  end
endmodule : svmon_bench
